// File: rtl/ext_edge_pkg.sv
// Purpose: Shared constants and carriers for the external edge interrupt block
// Assumes: 32-bit AXI4-Lite register bus, one clock at 25 MHz
// Notes:   Offsets are byte addresses of aligned words
package ext_edge_pkg;

  localparam int unsigned CLK_HZ         = 25_000_000;
  localparam int unsigned ADDR_W         = 8;

  // Register byte offsets
  localparam logic [7:0]  OFF_EDGE_SEL_A = 8'h00;
  localparam logic [7:0]  OFF_EDGE_SEL_B = 8'h04;
  localparam logic [7:0]  OFF_TEST_SRC   = 8'h08;
  localparam logic [7:0]  OFF_FLAGS      = 8'h0C;
  localparam logic [7:0]  OFF_WAKE       = 8'h10;
  localparam logic [7:0]  OFF_NOISE_CFG  = 8'h14;
  localparam logic [7:0]  OFF_PINS       = 8'h18;

  // Flag bit positions in the flag register
  localparam int unsigned FLAG_DUAL      = 0;
  localparam int unsigned FLAG_FILT      = 1;
  localparam int unsigned FLAG_ASYNC     = 2;
  localparam int unsigned FLAG_TEST      = 3;
  localparam int unsigned FLAG_KEY       = 4;
  localparam int unsigned NUM_FLAGS      = 5;

  // Reset values
  localparam logic [1:0]  EDGE_A_RST     = 2'h0;
  localparam logic        EDGE_B_RST     = 1'h0;
  localparam logic [1:0]  TEST_SRC_RST   = 2'h0;
  localparam logic        NOISE_CFG_RST  = 1'h0;

  // Filtered input edge select encoding
  localparam logic [1:0]  SEL_RISE       = 2'h0;
  localparam logic [1:0]  SEL_FALL       = 2'h1;
  localparam logic [1:0]  SEL_BOTH       = 2'h2;
  localparam logic [1:0]  SEL_OFF        = 2'h3;

  // Test source select: 0 test input, 1 key inputs to test flag, 2 key to interrupt only
  localparam logic [1:0]  TSRC_TEST_PIN  = 2'h0;
  localparam logic [1:0]  TSRC_KEY_TEST  = 2'h1;
  localparam logic [1:0]  TSRC_KEY_IRQ   = 2'h2;

  // Noise eliminator sampling periods in clock cycles, chosen by one config bit
  localparam logic [7:0]  NOISE_DIV_FAST = 8'h04;
  localparam logic [7:0]  NOISE_DIV_SLOW = 8'h40;
  localparam logic [1:0]  NOISE_AGREE    = 2'h2;

  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  typedef struct packed {
    logic        dual;
    logic        filt;
    logic        async_sel;
    logic        test;
    logic [7:0]  key;
  } pins_t;

endpackage : ext_edge_pkg

// File: rtl/ext_edge_irq.sv
// Purpose: Edge detection for external interrupt, test and key inputs
// Assumes: Pins are asynchronous to aclk; AXI4-Lite register slave
// Notes:   Standby release is a level output while standby is high and any wake source is pending
module ext_edge_irq (
  input  wire logic                aclk,
  input  wire logic                aresetn,
  input  wire logic                dual_edge_irq_pin,
  input  wire logic                filtered_irq_pin,
  input  wire logic                async_select_irq_pin,
  input  wire logic                rising_test_input,
  input  wire logic [7:0]          key_input_pins,
  input  wire logic                standby,
  input  wire logic                irq_ack_valid,
  input  wire logic [4:0]          irq_ack_mask,
  output logic     [4:0]           irq_flags,
  output logic                     test_event_flag,
  output logic                     wake_release,
  output logic     [7:0]           key_port_oe,
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic     [1:0]           s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic     [31:0]          s_axi_rdata,
  output logic     [1:0]           s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);

  typedef struct packed {
    ext_edge_pkg::pins_t sync1;
    ext_edge_pkg::pins_t sync2;
    ext_edge_pkg::pins_t prev;
    logic        [7:0]   noise_cnt;
    logic        [1:0]   agree_cnt;
    logic                filt_level;
    logic                filt_cand;
    logic        [1:0]   edge_sel_a;
    logic                edge_sel_b;
    logic        [1:0]   test_src;
    logic                noise_cfg;
    logic        [4:0]   flags;
    logic                aw_held;
    logic        [7:0]   aw_addr;
    logic                w_held;
    logic        [31:0]  w_data;
    logic        [3:0]   w_strb;
    logic                bvalid;
    logic        [1:0]   bresp;
    logic                rvalid;
    logic        [31:0]  rdata;
    logic        [1:0]   rresp;
  } state_t;

  state_t st_reg;
  state_t st_next;

  ext_edge_pkg::pins_t pins_in;
  assign pins_in = '{dual: dual_edge_irq_pin, filt: filtered_irq_pin,
                     async_sel: async_select_irq_pin, test: rising_test_input,
                     key: key_input_pins};

  logic        [4:0]  set_ev;
  logic        [4:0]  clr_ev;
  logic               filt_rise;
  logic               filt_fall;
  logic               filt_edge;
  logic               async_edge;
  logic               test_rise;
  logic               key_fall;
  logic               wr_fire;
  logic               rd_fire;
  logic        [31:0] wr_word;
  logic        [31:0] rd_word;
  logic               rd_ok;
  logic        [7:0]  noise_div;

  ////////////////////////////////////////////////////////////////////////////
  // Edge events on the second synchroniser stage; the filtered input edges on the noise filter output

  always_comb begin
    // Edge on sync2 vs prev: sync1 feeds only sync2
    filt_rise  = st_reg.filt_cand & ~st_reg.filt_level
                 & (st_reg.agree_cnt == ext_edge_pkg::NOISE_AGREE);
    filt_fall  = ~st_reg.filt_cand & st_reg.filt_level
                 & (st_reg.agree_cnt == ext_edge_pkg::NOISE_AGREE);
    unique case (st_reg.edge_sel_a)
      ext_edge_pkg::SEL_RISE: filt_edge = filt_rise;
      ext_edge_pkg::SEL_FALL: filt_edge = filt_fall;
      ext_edge_pkg::SEL_BOTH: filt_edge = filt_rise | filt_fall;
      ext_edge_pkg::SEL_OFF:  filt_edge = 1'b0;
    endcase
    async_edge = st_reg.edge_sel_b
                 ? (~st_reg.sync2.async_sel & st_reg.prev.async_sel)
                 : (st_reg.sync2.async_sel & ~st_reg.prev.async_sel);
    test_rise  = st_reg.sync2.test & ~st_reg.prev.test;
    key_fall   = |(~st_reg.sync2.key & st_reg.prev.key);
    set_ev = '0;
    set_ev[ext_edge_pkg::FLAG_DUAL]  = st_reg.sync2.dual ^ st_reg.prev.dual;
    set_ev[ext_edge_pkg::FLAG_FILT]  = filt_edge;
    set_ev[ext_edge_pkg::FLAG_ASYNC] = async_edge;
    set_ev[ext_edge_pkg::FLAG_KEY]   = key_fall &
                                       (st_reg.test_src != ext_edge_pkg::TSRC_KEY_TEST);
    unique case (st_reg.test_src)
      ext_edge_pkg::TSRC_TEST_PIN: set_ev[ext_edge_pkg::FLAG_TEST] = test_rise;
      ext_edge_pkg::TSRC_KEY_TEST: set_ev[ext_edge_pkg::FLAG_TEST] = key_fall;
      default:                     set_ev[ext_edge_pkg::FLAG_TEST] = 1'b0;
    endcase
  end

  assign noise_div = st_reg.noise_cfg ? ext_edge_pkg::NOISE_DIV_SLOW
                                      : ext_edge_pkg::NOISE_DIV_FAST;

  ////////////////////////////////////////////////////////////////////////////
  // Register bus decode

  assign wr_fire = st_reg.aw_held & st_reg.w_held & ~st_reg.bvalid;
  assign rd_fire = s_axi_arvalid & ~st_reg.rvalid;

  always_comb begin
    rd_ok   = 1'b1;
    rd_word = '0;
    unique case (s_axi_araddr)
      ext_edge_pkg::OFF_EDGE_SEL_A: rd_word = {30'h0, st_reg.edge_sel_a};
      ext_edge_pkg::OFF_EDGE_SEL_B: rd_word = {31'h0, st_reg.edge_sel_b};
      ext_edge_pkg::OFF_TEST_SRC:   rd_word = {30'h0, st_reg.test_src};
      ext_edge_pkg::OFF_FLAGS:      rd_word = {27'h0, st_reg.flags};
      ext_edge_pkg::OFF_WAKE:       rd_word = {31'h0, wake_release};
      ext_edge_pkg::OFF_NOISE_CFG:  rd_word = {31'h0, st_reg.noise_cfg};
      ext_edge_pkg::OFF_PINS:       rd_word = {20'h0, st_reg.sync2.key, st_reg.sync2.test,
                                               st_reg.sync2.async_sel, st_reg.filt_level,
                                               st_reg.sync2.dual};
      default:                      rd_ok   = 1'b0;
    endcase
  end

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wr_word[i*8 +: 8] = st_reg.w_strb[i] ? st_reg.w_data[i*8 +: 8] : 8'h00;
    end
  end

  always_comb begin
    clr_ev = irq_ack_valid ? irq_ack_mask : 5'h00;
    if (wr_fire && st_reg.aw_addr == ext_edge_pkg::OFF_FLAGS) begin
      clr_ev = clr_ev | wr_word[4:0];       // Write one to clear
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    st_next = st_reg;
    st_next.sync1 = pins_in;
    st_next.sync2 = st_reg.sync1;
    st_next.prev  = st_reg.sync2;

    // Filtered input: sampled on a divided strobe, accepted after agreeing samples
    if (st_reg.noise_cnt >= noise_div - 8'h01) begin
      st_next.noise_cnt = 8'h00;
      if (st_reg.sync2.filt != st_reg.filt_cand) begin
        st_next.filt_cand = st_reg.sync2.filt;
        st_next.agree_cnt = 2'h1;
      end else if (st_reg.agree_cnt != ext_edge_pkg::NOISE_AGREE) begin
        st_next.agree_cnt = st_reg.agree_cnt + 2'h1;
      end
    end else begin
      st_next.noise_cnt = st_reg.noise_cnt + 8'h01;
    end
    if (st_reg.agree_cnt == ext_edge_pkg::NOISE_AGREE) begin
      st_next.filt_level = st_reg.filt_cand;
    end

    st_next.flags = (st_reg.flags & ~clr_ev) | set_ev;

    // AXI write side: address and data taken in either order
    if (s_axi_awvalid && !st_reg.aw_held) begin
      st_next.aw_held = 1'b1;
      st_next.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st_reg.w_held) begin
      st_next.w_held = 1'b1;
      st_next.w_data = s_axi_wdata;
      st_next.w_strb = s_axi_wstrb;
    end
    if (wr_fire) begin
      st_next.aw_held = 1'b0;
      st_next.w_held  = 1'b0;
      st_next.bvalid  = 1'b1;
      st_next.bresp   = ext_edge_pkg::RESP_OKAY;
      unique case (st_reg.aw_addr)
        ext_edge_pkg::OFF_EDGE_SEL_A: begin
          if (st_reg.w_strb[0]) st_next.edge_sel_a = st_reg.w_data[1:0];
        end
        ext_edge_pkg::OFF_EDGE_SEL_B: begin
          if (st_reg.w_strb[0]) st_next.edge_sel_b = st_reg.w_data[0];
        end
        ext_edge_pkg::OFF_TEST_SRC: begin
          if (st_reg.w_strb[0]) st_next.test_src = st_reg.w_data[1:0];
        end
        ext_edge_pkg::OFF_NOISE_CFG: begin
          if (st_reg.w_strb[0]) st_next.noise_cfg = st_reg.w_data[0];
        end
        ext_edge_pkg::OFF_FLAGS, ext_edge_pkg::OFF_WAKE, ext_edge_pkg::OFF_PINS: begin
        end
        default: st_next.bresp = ext_edge_pkg::RESP_SLVERR;
      endcase
    end
    if (st_reg.bvalid && s_axi_bready) begin
      st_next.bvalid = 1'b0;
    end

    // AXI read side: single cycle answer
    if (rd_fire) begin
      st_next.rvalid = 1'b1;
      st_next.rdata  = rd_word;
      st_next.rresp  = rd_ok ? ext_edge_pkg::RESP_OKAY : ext_edge_pkg::RESP_SLVERR;
    end else if (st_reg.rvalid && s_axi_rready) begin
      st_next.rvalid = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register; reset overrides every other update

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_reg            <= '0;
      st_reg.edge_sel_a <= ext_edge_pkg::EDGE_A_RST;
      st_reg.edge_sel_b <= ext_edge_pkg::EDGE_B_RST;
      st_reg.test_src   <= ext_edge_pkg::TSRC_TEST_PIN;
      st_reg.noise_cfg  <= ext_edge_pkg::NOISE_CFG_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  // Filtered input is left out so it can never end standby
  assign wake_release = ~aresetn
                        | (standby & (st_reg.flags[ext_edge_pkg::FLAG_DUAL]
                        | st_reg.flags[ext_edge_pkg::FLAG_ASYNC]
                        | st_reg.flags[ext_edge_pkg::FLAG_TEST]));
  assign irq_flags       = st_reg.flags;
  assign test_event_flag = st_reg.flags[ext_edge_pkg::FLAG_TEST];
  assign key_port_oe     = 8'hFF;    // Key pins never driven: plain inputs
  assign s_axi_awready   = ~st_reg.aw_held;
  assign s_axi_wready    = ~st_reg.w_held;
  assign s_axi_bvalid    = st_reg.bvalid;
  assign s_axi_bresp     = st_reg.bresp;
  assign s_axi_arready   = ~st_reg.rvalid;
  assign s_axi_rvalid    = st_reg.rvalid;
  assign s_axi_rdata     = st_reg.rdata;
  assign s_axi_rresp     = st_reg.rresp;

endmodule : ext_edge_irq

// File: tb/ext_edge_irq_properties.sv
// Purpose: Port-level checks of the external edge interrupt block
// Assumes: One aclk domain, aresetn synchronous and active low
// Notes:   Pin-to-flag bound leaves room for the two-flop synchroniser
module ext_edge_irq_properties (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       dual_edge_irq_pin,
  input wire logic       standby,
  input wire logic       irq_ack_valid,
  input wire logic [4:0] irq_flags,
  input wire logic       test_event_flag,
  input wire logic       wake_release,
  input wire logic [7:0] key_port_oe,
  input wire logic       s_axi_wvalid,
  input wire logic       s_axi_bvalid,
  input wire logic       s_axi_arvalid,
  input wire logic       s_axi_arready,
  input wire logic       s_axi_rvalid
);
  wire logic wake_src = irq_flags[0] | irq_flags[2] | irq_flags[3];
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////
  AST_KEY_OE: assert property (key_port_oe == 8'hFF)
    else $error("key pins left input mode");
  AST_TEST_MIRROR: assert property (test_event_flag == irq_flags[3])
    else $error("test flag output differs from flag bit");
  AST_RESET_CLEAR: assert property ($rose(aresetn) |-> irq_flags == 5'h00 && !s_axi_rvalid)
    else $error("state not cleared by reset");
  AST_WAKE: assert property (wake_release == (standby && wake_src))
    else $error("wake release does not follow wake sources");
  AST_DUAL_EDGE: assert property ($changed(dual_edge_irq_pin) |-> ##[1:5] irq_flags[0])
    else $error("dual edge change did not set its flag");
  AST_SYNC_DELAY: assert property ($changed(dual_edge_irq_pin) && !irq_flags[0] |=> !irq_flags[0])
    else $error("dual edge flag skipped the synchroniser");
  AST_READ_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer not one cycle after address");
  // Writes are excluded since a flag write-one-to-clear may be in flight
  AST_STICKY: assert property (irq_flags[0] && !irq_ack_valid && !s_axi_wvalid
    && !s_axi_bvalid && !$past(s_axi_wvalid) |=> irq_flags[0])
    else $error("flag dropped without a clear");
endmodule : ext_edge_irq_properties

bind ext_edge_irq ext_edge_irq_properties u_props (
  .aclk, .aresetn, .dual_edge_irq_pin, .standby, .irq_ack_valid, .irq_flags,
  .test_event_flag, .wake_release, .key_port_oe, .s_axi_wvalid, .s_axi_bvalid,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid
);

// File: tb/pin_model.sv
// Purpose: Model of the pins and keys facing the block
// Assumes: Bench sets levels just after an aclk edge
// Notes:   Keys idle high so a press is a falling edge
module pin_model (
  input  wire ext_edge_pkg::pins_t level,
  input  wire logic                aclk,
  output var  ext_edge_pkg::pins_t pins
);
  timeunit 1ns;
  timeprecision 1ns;
  initial pins = 12'h0FF;
  always @(posedge aclk) begin
    pins <= level;
  end
endmodule : pin_model

// File: tb/ext_edge_irq_test.sv
// Purpose: Self-checking bench of the external edge interrupt block
// Assumes: Flags settle within 40 cycles of a pin change
// Notes:   Standby stays high after the reset checks so wake is seen
module ext_edge_irq_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic                aclk = 1'b0;
  logic                aresetn = 1'b0;
  logic                standby = 1'b0;
  logic                irq_ack_valid = 1'b0;
  logic [7:0]          s_axi_awaddr = 8'h00;
  logic [7:0]          s_axi_araddr = 8'h00;
  logic [31:0]         s_axi_wdata = 32'h0000_0000;
  logic                s_axi_awvalid = 1'b0;
  logic                s_axi_wvalid = 1'b0;
  logic                s_axi_bready = 1'b0;
  logic                s_axi_arvalid = 1'b0;
  logic                s_axi_rready = 1'b0;
  logic [4:0]          irq_flags;
  logic [7:0]          key_port_oe;
  logic [31:0]         s_axi_rdata;
  logic [1:0]          s_axi_bresp, s_axi_rresp;
  logic                test_event_flag, wake_release, s_axi_awready, s_axi_wready;
  logic                s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  ext_edge_pkg::pins_t level = 12'h0FF;
  ext_edge_pkg::pins_t pins;
  int                  fails = 0;
  int                  samples_checked = 0;
  int                  cycles = 0;
  ////////////////////////////////////////
  pin_model pm (.level, .aclk, .pins);
  ext_edge_irq dut (
    .aclk, .aresetn, .standby, .irq_ack_valid, .irq_ack_mask(5'h1F), .irq_flags,
    .test_event_flag, .wake_release, .key_port_oe, .dual_edge_irq_pin(pins.dual),
    .filtered_irq_pin(pins.filt), .async_select_irq_pin(pins.async_sel),
    .rising_test_input(pins.test), .key_input_pins(pins.key), .s_axi_awaddr,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready
  );
  always #20 aclk = ~aclk;
  // Whole run is about 3200 cycles
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fails = fails + 1;
      finish_test();
    end
  end
  ////////////////////////////////////////
  task check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : check_val
  task check_bit(input string nm, input logic e, input logic g);
    check_val(nm, {31'h0, e}, {31'h0, g});
  endtask : check_bit
  task finish_test();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : finish_test
  task axi_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    check_val("bresp", 32'h0000_0000, {30'h0, s_axi_bresp});
  endtask : axi_write
  task axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    check_val("rdata", d, s_axi_rdata);
    check_val("rresp", {30'h0, r}, {30'h0, s_axi_rresp});
  endtask : axi_read
  task drive(input ext_edge_pkg::pins_t v);
    @(posedge aclk);
    level <= v;
    repeat (40) @(posedge aclk);
  endtask : drive
  // Moves the pins, checks all flags and wake, then acknowledges everything
  task step(input ext_edge_pkg::pins_t v, input logic [4:0] e);
    drive(v);
    check_val("irq_flags", {27'h0, e}, {27'h0, irq_flags});
    check_bit("wake_release", standby && (e[0] || e[2] || e[3]), wake_release);
    irq_ack_valid <= 1'b1;
    @(posedge aclk);
    irq_ack_valid <= 1'b0;
  endtask : step
  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    check_val("key_port_oe", 32'h0000_00FF, {24'h0, key_port_oe});
    for (int i = 0; i < 4; i++) begin
      axi_read(8'(4 * i), 32'h0000_0000, 2'h0);
    end
    axi_read(8'h20, 32'h0000_0000, 2'h2);
    standby <= 1'b1;
    step(12'h8FF, 5'h01);
    step(12'h0FF, 5'h01);
    drive(12'h8FF);
    axi_read(8'h0C, 32'h0000_0001, 2'h0);
    axi_write(8'h0C, 32'h0000_0001);
    axi_read(8'h0C, 32'h0000_0000, 2'h0);
    step(12'h0FF, 5'h01);
    for (int s = 0; s < 4; s++) begin
      axi_write(8'h00, 32'(s));
      axi_read(8'h00, 32'(s), 2'h0);
      step(12'h4FF, {3'h0, s == 0 || s == 2, 1'b0});
      step(12'h0FF, {3'h0, s == 1 || s == 2, 1'b0});
    end
    for (int b = 0; b < 2; b++) begin
      axi_write(8'h04, 32'(b));
      step(12'h2FF, {2'h0, b == 0, 2'h0});
      step(12'h0FF, {2'h0, b == 1, 2'h0});
    end
    for (int s = 0; s < 3; s++) begin
      axi_write(8'h08, 32'(s));
      step(12'h1FF, {1'b0, s == 0, 3'h0});
      step(12'h0FF, 5'h00);
      for (int k = 0; k < 8; k++) begin
        step(12'h0FF ^ (12'h001 << k), {s != 1, s == 1, 3'h0});
        step(12'h0FF, 5'h00);
      end
    end
    axi_write(8'h00, 32'h0000_0000);
    // An eleven-cycle pulse passes the fast filter but not the slow one
    for (int n = 0; n < 2; n++) begin
      axi_write(8'h14, 32'(1 - n));
      @(posedge aclk);
      level <= 12'h4FF;
      repeat (10) @(posedge aclk);
      step(12'h0FF, {3'h0, n == 1, 1'b0});
    end
    axi_write(8'h00, 32'h0000_0002);
    drive(12'h8FF);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    check_bit("wake_release", 1'b1, wake_release);
    check_val("irq_flags", 32'h0000_0000, {27'h0, irq_flags});
    aresetn <= 1'b1;
    axi_read(8'h00, 32'h0000_0000, 2'h0);
    finish_test();
  end
endmodule : ext_edge_irq_test
